/* pkg/bfs_pkg.sv */
/*
 * bfs_pkg: constants, thresholds and state type for the buck fault and
 * start-up sequencer. Assumes a 100 MHz core clock; monitor samples arrive
 * as plain binary values in mV and degrees C.
 */
`default_nettype none
package bfs_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int DETECT_TIME_US = 800;
   localparam int DETECT_CYC     = DETECT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int IDLE_TIME_MS   = 6;
   localparam int IDLE_CYC       = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TMR_W          = 20;

   // ----------------------------------------------------------------
   // monitor thresholds
   // ----------------------------------------------------------------
   localparam logic [11:0] EN_ON_MV    = 12'h276;  // 630 mV
   localparam logic [11:0] EN_HYST_MV  = 12'h01E;  // 30 mV
   localparam logic [11:0] EN_OFF_MV   = EN_ON_MV - EN_HYST_MV;
   localparam logic [15:0] LOCKOUT_MV  = 16'h0A5A; // 2650 mV
   localparam logic [7:0]  OT_ON_C     = 8'h9B;    // 155 C
   localparam logic [7:0]  OT_OFF_C    = 8'h8C;    // 140 C

   // ----------------------------------------------------------------
   // violation counting and sense gain codes
   // ----------------------------------------------------------------
   localparam logic [5:0]  VIOL_LIMIT  = 6'h20;    // 32 violations
   localparam logic [1:0]  GCODE_47K   = 2'h0;
   localparam logic [1:0]  GCODE_22K   = 2'h1;
   localparam logic [1:0]  GCODE_OPEN  = 2'h2;
   localparam logic [1:0]  GCODE_100K  = 2'h3;
   localparam logic [4:0]  GAIN_3      = 5'h03;
   localparam logic [4:0]  GAIN_6      = 5'h06;
   localparam logic [4:0]  GAIN_12     = 5'h0C;
   localparam logic [4:0]  GAIN_24     = 5'h18;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_DETECT,
      ST_SOFT,
      ST_RUN,
      ST_IDLE
   } bfs_state_type;

endpackage
`default_nettype wire

/* pkg/bfs_gate_if.sv */
/*
 * bfs_gate_if: carries drive permission and the pwm request from the
 * sequencer to the gate-drive interlock, and the gate states back.
 * Assumes both ends share core_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
interface bfs_gate_if;
   logic drive_en;
   logic pwm;
   logic upper_gate_drive;
   logic lower_gate_drive;

   modport seq (output drive_en, output pwm, input upper_gate_drive, input lower_gate_drive);
   modport drv (input drive_en, input pwm, output upper_gate_drive, output lower_gate_drive);
endinterface
`default_nettype wire

/* rtl/bfs_gate_drive.sv */
/*
 * bfs_gate_drive: complementary upper/lower gate drive with interlock.
 * Assumes drive_en and pwm are synchronous to core_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module bfs_gate_drive (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   bfs_gate_if.drv   gate
);

   logic upper_reg;
   logic lower_reg;
   logic upper_next;
   logic lower_next;

   // ----------------------------------------------------------------
   // interlock: a switch turns on only once the other is seen off,
   // which inserts one dead cycle at every transition
   // ----------------------------------------------------------------
   assign upper_next = gate.drive_en & gate.pwm & ~lower_reg;
   assign lower_next = gate.drive_en & ~gate.pwm & ~upper_reg;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         upper_reg <= 1'b0;
         lower_reg <= 1'b0;
      end else begin
         upper_reg <= upper_next;
         lower_reg <= lower_next;
      end
   end

   assign gate.upper_gate_drive = upper_reg;
   assign gate.lower_gate_drive = lower_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_no_overlap;
      @(posedge core_clk_i) disable iff (rst_i)
      !(upper_reg && lower_reg);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

   property p_upper_dead;
      @(posedge core_clk_i) disable iff (rst_i)
      $rose(upper_reg) |-> !$past(lower_reg);
   endproperty
   a_upper_dead: assert property (p_upper_dead) else $error("no dead cycle");

   property p_gate_off;
      @(posedge core_clk_i) disable iff (rst_i)
      !gate.drive_en |=> !upper_reg && !lower_reg;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate on while disabled");

endmodule
`default_nettype wire

/* rtl/bfs_sequencer.sv */
/*
 * bfs_sequencer: start-up and protection sequencer for a synchronous buck
 * controller. Holds enable, lockout and thermal flags, runs gain detection
 * before soft start, counts valley current-limit violations and runs hiccup
 * recovery. Assumes monitor samples and comparator levels are synchronous
 * to core_clk_i, and that the soft-start ramp reports its own completion.
 */
`timescale 1ns/100ps
`default_nettype none
module bfs_sequencer #(
   parameter int DETECT_CYC = bfs_pkg::DETECT_CYC,
   parameter int IDLE_CYC   = bfs_pkg::IDLE_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [11:0] en_mv_i,
   input  wire logic [15:0] vin_mv_i,
   input  wire logic [7:0]  temp_c_i,
   input  wire logic [1:0]  gain_code_i,
   input  wire logic        valley_limit_i,
   input  wire logic        ss_done_i,
   input  wire logic        pwm_i,
   output logic             upper_gate_drive_o,
   output logic             lower_gate_drive_o,
   output logic [1:0]       gain_code_o,
   output logic [4:0]       sense_gain_o,
   output logic             low_power_o,
   output logic             thermal_o,
   output logic             hiccup_o
);

   bfs_gate_if gate ();

   bfs_pkg::bfs_state_type state_reg;
   bfs_pkg::bfs_state_type state_next;
   logic [bfs_pkg::TMR_W-1:0] tmr_reg;
   logic [5:0]  viol_reg;
   logic        en_on_reg;
   logic        ot_reg;
   logic        lock_reg;
   logic        lim_d_reg;
   logic        retry_reg;
   logic        pdown_reg;
   logic [1:0]  gain_code_reg;
   logic [4:0]  sense_gain_reg;
   logic        low_power_reg;
   logic        hiccup_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire en_rise   = en_mv_i > bfs_pkg::EN_ON_MV;
   wire en_fall   = en_mv_i < bfs_pkg::EN_OFF_MV;
   wire ot_rise   = temp_c_i > bfs_pkg::OT_ON_C;
   wire ot_fall   = temp_c_i < bfs_pkg::OT_OFF_C;
   wire active_w  = en_on_reg & ~lock_reg & ~ot_reg;
   wire viol_ev   = valley_limit_i & ~lim_d_reg;
   wire viol_full = viol_ev & (viol_reg == bfs_pkg::VIOL_LIMIT - 6'h01);
   wire det_end   = tmr_reg == bfs_pkg::TMR_W'(DETECT_CYC - 1);
   wire idle_end  = tmr_reg == bfs_pkg::TMR_W'(IDLE_CYC - 1);
   wire driving_w = (state_reg == bfs_pkg::ST_SOFT) | (state_reg == bfs_pkg::ST_RUN);
   // a retry ramp trips on the first violation rather than waiting for 32
   wire trip_w    = (state_reg == bfs_pkg::ST_SOFT && retry_reg) ? viol_ev : viol_full;

   assign gate.drive_en = active_w & driving_w;
   assign gate.pwm      = pwm_i;

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bfs_pkg::ST_OFF:    state_next = bfs_pkg::ST_DETECT;
         bfs_pkg::ST_DETECT: if (det_end) state_next = bfs_pkg::ST_SOFT;
         bfs_pkg::ST_SOFT: begin
            if (trip_w) state_next = bfs_pkg::ST_IDLE;
            else if (ss_done_i) state_next = bfs_pkg::ST_RUN;
         end
         bfs_pkg::ST_RUN:    if (viol_full) state_next = bfs_pkg::ST_IDLE;
         bfs_pkg::ST_IDLE: begin
            if (idle_end) begin
               state_next = pdown_reg ? bfs_pkg::ST_OFF : bfs_pkg::ST_SOFT;
            end
         end
         default:            state_next = bfs_pkg::ST_OFF;
      endcase
      if (!active_w) state_next = bfs_pkg::ST_OFF;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         en_on_reg <= 1'b0;
         ot_reg    <= 1'b0;
         lock_reg  <= 1'b1;
         lim_d_reg <= 1'b0;
      end else begin
         en_on_reg <= en_on_reg ? ~en_fall : en_rise;
         ot_reg    <= ot_reg ? ~ot_fall : ot_rise;
         lock_reg  <= vin_mv_i < bfs_pkg::LOCKOUT_MV;
         lim_d_reg <= valley_limit_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= bfs_pkg::ST_OFF;
         tmr_reg   <= '0;
         viol_reg  <= '0;
         retry_reg <= 1'b0;
         pdown_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // timer restarts on every state change
         tmr_reg   <= (state_next != state_reg || !active_w) ? '0 : tmr_reg + 1'b1;
         if (!active_w || state_next == bfs_pkg::ST_IDLE || state_next == bfs_pkg::ST_OFF) begin
            viol_reg <= '0;
         end else if (viol_ev) begin
            viol_reg <= viol_reg + 6'h01;
         end
         if (!active_w || state_next == bfs_pkg::ST_RUN || state_next == bfs_pkg::ST_OFF) begin
            retry_reg <= 1'b0;
         end else if (state_reg == bfs_pkg::ST_IDLE && state_next == bfs_pkg::ST_SOFT) begin
            retry_reg <= 1'b1;
         end
         if (!active_w || state_next == bfs_pkg::ST_OFF) begin
            pdown_reg <= 1'b0;
         end else if (state_reg == bfs_pkg::ST_SOFT && retry_reg && viol_ev) begin
            pdown_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // gain detection and status
   // ----------------------------------------------------------------
   wire [4:0] gain_map = (gain_code_i == bfs_pkg::GCODE_47K)  ? bfs_pkg::GAIN_3  :
                         (gain_code_i == bfs_pkg::GCODE_22K)  ? bfs_pkg::GAIN_6  :
                         (gain_code_i == bfs_pkg::GCODE_OPEN) ? bfs_pkg::GAIN_12 :
                                                                bfs_pkg::GAIN_24;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         gain_code_reg  <= bfs_pkg::GCODE_OPEN;
         sense_gain_reg <= bfs_pkg::GAIN_12;
         low_power_reg  <= 1'b1;
         hiccup_reg     <= 1'b0;
      end else begin
         if (state_reg == bfs_pkg::ST_DETECT && det_end) begin
            gain_code_reg  <= gain_code_i;
            sense_gain_reg <= gain_map;
         end
         low_power_reg  <= ~en_on_reg;
         hiccup_reg     <= state_next == bfs_pkg::ST_IDLE;
      end
   end

   bfs_gate_drive u_drive (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .gate       (gate)
   );

   assign upper_gate_drive_o = gate.upper_gate_drive;
   assign lower_gate_drive_o = gate.lower_gate_drive;
   assign gain_code_o        = gain_code_reg;
   assign sense_gain_o       = sense_gain_reg;
   assign low_power_o        = low_power_reg;
   assign thermal_o          = ot_reg;
   assign hiccup_o           = hiccup_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_detect_done;
      state_reg == bfs_pkg::ST_DETECT ##1 state_reg == bfs_pkg::ST_SOFT;
   endsequence

   sequence s_idle_done;
      state_reg == bfs_pkg::ST_IDLE && idle_end && active_w && !pdown_reg;
   endsequence

   property p_en_hyst;
      en_on_reg && en_mv_i >= bfs_pkg::EN_OFF_MV |=> en_on_reg;
   endproperty
   a_en_hyst: assert property (p_en_hyst) else $error("enable dropped in band");

   property p_lockout_off;
      vin_mv_i < bfs_pkg::LOCKOUT_MV |-> ##2 !upper_gate_drive_o && !lower_gate_drive_o;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("gate on under lockout");

   property p_ot_off;
      temp_c_i > bfs_pkg::OT_ON_C |->
         ##1 thermal_o ##1 !upper_gate_drive_o && !lower_gate_drive_o;
   endproperty
   a_ot_off: assert property (p_ot_off) else $error("gate on when hot");

   property p_ot_hold;
      ot_reg && temp_c_i >= bfs_pkg::OT_OFF_C |=> ot_reg && state_reg == bfs_pkg::ST_OFF;
   endproperty
   a_ot_hold: assert property (p_ot_hold) else $error("thermal released early");

   property p_soft_after_detect;
      $rose(state_reg == bfs_pkg::ST_SOFT) |->
         $past(state_reg) inside {bfs_pkg::ST_DETECT, bfs_pkg::ST_IDLE};
   endproperty
   a_soft_after_detect: assert property (p_soft_after_detect)
      else $error("soft start skipped detect");

   property p_gain_latch;
      s_detect_done |-> gain_code_o == $past(gain_code_i) && $past(det_end);
   endproperty
   a_gain_latch: assert property (p_gain_latch) else $error("gain code not latched");

   property p_viol_idle;
      viol_full && state_reg == bfs_pkg::ST_RUN && active_w |=>
         state_reg == bfs_pkg::ST_IDLE && hiccup_o
         ##1 !upper_gate_drive_o && !lower_gate_drive_o;
   endproperty
   a_viol_idle: assert property (p_viol_idle) else $error("no idle after violations");

   property p_idle_restart;
      s_idle_done |=> state_reg == bfs_pkg::ST_SOFT && retry_reg && tmr_reg == '0;
   endproperty
   a_idle_restart: assert property (p_idle_restart) else $error("no restart after idle");

   property p_retry_pdown;
      state_reg == bfs_pkg::ST_SOFT && retry_reg && viol_ev && active_w |=>
         state_reg == bfs_pkg::ST_IDLE && pdown_reg;
   endproperty
   a_retry_pdown: assert property (p_retry_pdown) else $error("retry fault not caught");

endmodule
`default_nettype wire

/* dv/bfs_fet_model.sv */
/*
 * bfs_fet_model: behavioural pair of external power switches at the gate
 * outputs. Assumes gates are active high and synchronous to core_clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module bfs_fet_model (
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic       upper_gate_drive_i,
   input  wire logic       lower_gate_drive_i,
   input  wire logic       short_i,
   output logic            valley_limit_o,
   output logic [7:0]      overlap_cnt_o
);
   // ----------------------------------------------------------------
   // valley comparator and shoot-through watch
   // ----------------------------------------------------------------
   wire logic both_on;
   // limit trips only while the lower switch conducts into a short
   assign valley_limit_o = short_i & lower_gate_drive_i;
   assign both_on        = upper_gate_drive_i & lower_gate_drive_i;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         overlap_cnt_o <= 8'h00;
      end else if (both_on && overlap_cnt_o != 8'hFF) begin
         overlap_cnt_o <= overlap_cnt_o + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* dv/buck_fault_startup_sequencer_tb.sv */
/*
 * buck_fault_startup_sequencer_tb: self-checking bench for bfs_sequencer
 * with the switch model. Assumes short detect and idle counts.
 */
`timescale 1ns/100ps
`default_nettype none
module buck_fault_startup_sequencer_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int DET = 20;
   localparam int IDL = 30;
   logic             core_clk_i;
   logic             rst_i;
   logic [11:0]      en_mv_i;
   logic [15:0]      vin_mv_i;
   logic [7:0]       temp_c_i;
   logic [1:0]       gain_code_i;
   logic             ss_done_i;
   logic             pwm_i;
   logic             short_on;
   wire logic        valley_limit;
   wire logic        up_g;
   wire logic        lo_g;
   wire logic [1:0]  gc_o;
   wire logic [4:0]  sg_o;
   wire logic        lp_o;
   wire logic        th_o;
   wire logic        hc_o;
   wire logic [7:0]  overlap;
   wire logic [11:0] obs;
   logic [23:0]      exp_q [$];
   logic [23:0]      e;
   logic [4:0]       gain_tab [4] = '{5'h03, 5'h06, 5'h0C, 5'h18};
   int               mismatches;
   int               n_tests;
   event             chk_ev;
   assign obs = {up_g, lo_g, lp_o, th_o, hc_o, gc_o, sg_o};

   bfs_sequencer #(.DETECT_CYC(DET), .IDLE_CYC(IDL)) DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .en_mv_i(en_mv_i), .vin_mv_i(vin_mv_i),
      .temp_c_i(temp_c_i), .gain_code_i(gain_code_i), .valley_limit_i(valley_limit),
      .ss_done_i(ss_done_i), .pwm_i(pwm_i), .upper_gate_drive_o(up_g),
      .lower_gate_drive_o(lo_g), .gain_code_o(gc_o), .sense_gain_o(sg_o),
      .low_power_o(lp_o), .thermal_o(th_o), .hiccup_o(hc_o));
   bfs_fet_model fets (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .upper_gate_drive_i(up_g),
      .lower_gate_drive_i(lo_g), .short_i(short_on), .valley_limit_o(valley_limit),
      .overlap_cnt_o(overlap));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // mask selects the observed fields: gates, low power, thermal, idle, gain
   task automatic chk(input logic [11:0] m, input logic [11:0] v);
      exp_q.push_back({m, v});
      ->chk_ev;
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // detect holds both gates off, then soft start drives the upper gate
   task automatic boot(input logic [1:0] gc);
      gain_code_i = gc;
      en_mv_i = 12'(631 + $urandom_range(2000));
      cyc(3);
      chk(12'hE00, 12'h000);
      cyc(DET - 4);
      chk(12'hC00, 12'h000);
      cyc(10);
      chk(12'hC7F, {2'b10, 3'b000, gc, gain_tab[gc]});
   endtask
   // one low pwm phase gives one lower-switch conduction interval
   task automatic pulses(input int n);
      repeat (n) begin
         pwm_i = 1'b0;
         cyc(3);
         chk(12'hC00, 12'h400);
         cyc(1);
         pwm_i = 1'b1;
         cyc(4);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // monitor and watchdog
   // ----------------------------------------------------------------
   initial forever begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         n_tests++;
         if ((obs & e[23:12]) !== e[11:0]) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, obs & e[23:12], e[11:0]);
         end
      end
   end
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      en_mv_i = 12'h000;
      vin_mv_i = 16'h0CE4;
      temp_c_i = 8'h19;
      gain_code_i = 2'h2;
      ss_done_i = 1'b0;
      pwm_i = 1'b1;
      short_on = 1'b0;
      void'($urandom(93));
      cyc(4);
      chk(12'hFFF, 12'h24C);
      rst_i = 1'b0;
      vin_mv_i = 16'(2650 + $urandom_range(9000));
      en_mv_i = 12'h276;
      cyc(8);
      chk(12'hE00, 12'h200);
      en_mv_i = 12'h000;
      cyc(8);
      chk(12'hE00, 12'h200);
      done("enable_threshold");
      for (int g = 0; g < 4; g++) begin
         boot(2'(g));
         en_mv_i = 12'h258;
         cyc(4);
         chk(12'hE00, 12'h800);
         en_mv_i = 12'($urandom_range(599));
         cyc(4);
         chk(12'hE00, 12'h200);
      end
      done("gain_startup");
      boot(2'($urandom_range(3)));
      vin_mv_i = 16'h0A59;
      cyc(4);
      chk(12'hC00, 12'h000);
      vin_mv_i = 16'h0A5A;
      boot(2'h1);
      done("lockout");
      temp_c_i = 8'h9B;
      cyc(4);
      chk(12'hD00, 12'h800);
      temp_c_i = 8'h9C;
      cyc(3);
      chk(12'hD00, 12'h100);
      temp_c_i = 8'h8C;
      cyc(6);
      chk(12'hD00, 12'h100);
      temp_c_i = 8'(20 + $urandom_range(119));
      boot(2'h3);
      chk(12'h100, 12'h000);
      done("thermal");
      ss_done_i = 1'b1;
      short_on = 1'b1;
      cyc(2);
      pulses(31);
      chk(12'h080, 12'h000);
      pulses(1);
      ss_done_i = 1'b0;
      cyc(2);
      chk(12'hC80, 12'h080);
      cyc(15);
      chk(12'hC80, 12'h080);
      cyc(IDL);
      chk(12'hC80, 12'h800);
      pulses(1);
      cyc(2);
      chk(12'hC80, 12'h080);
      cyc(IDL);
      chk(12'hC80, 12'h000);
      short_on = 1'b0;
      cyc(DET + 8);
      chk(12'hC80, 12'h800);
      ss_done_i = 1'b1;
      pulses(40);
      chk(12'h080, 12'h000);
      done("hiccup");
      // 20 violations before and 20 after a disable must not reach 32
      short_on = 1'b1;
      pulses(20);
      en_mv_i = 12'($urandom_range(599));
      cyc(4);
      chk(12'hE80, 12'h200);
      boot(2'h0);
      pulses(20);
      chk(12'hC80, 12'h800);
      short_on = 1'b0;
      done("count_clear");
      n_tests++;
      if (overlap !== 8'h00) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, overlap, 8'h00);
      end
      done("interlock");
      cyc(2);
      wrap_up();
   end
endmodule
`default_nettype wire
